// ===== qot_regs.svh
// Register offsets, field positions, reset values and divider counts of the timer channel
// How it works
// R1: Two-phase counting exists only on channels 2, 3 and 4.
// R2: Two-phase counting takes events from count_in_pin and count_out_pin.
// R3: Two-phase overflow or underflow reloads the reload value and keeps counting.
// R4: Free-run skips the reload and lets the counter wrap.
// R5: Ratio is 1/(FFFF-n+1) counting up and 1/(n+1) counting down.
// R6: Two-phase counting runs while the count-start flag is 1.
// R7: Two-phase overflow or underflow raises the interrupt request.
// R8: Software must make both pins inputs before two-phase use.
// R9: Two-phase counter reads return the live count.
// R10: Writes while stopped load reload and counter; while counting, reload only.
// R11: Normal decoding: count_out_pin high, count_in_pin rise up, fall down.
// R12: Times four: count_in_pin rising while count_out_pin high counts all edges up.
// R13: Times four: count_in_pin falling while count_out_pin high counts all edges down.
// R14: Decoding selectable on channel 3; channel 2 normal, channel 4 times four.
// R15: One-shot counts down from undivided, div8, div32 or subclock div32.
// R16: One-shot reaching zero reloads the programmed value and stops.
// R17: A trigger during a one-shot reloads and restarts the countdown.
// R18: One-shot starts on pin trigger, source timer overflow or software start.
// R19: Clearing the count-start flag stops a one-shot at once.
// R20: One-shot reaching zero raises the interrupt request.
// R21: One-shot counter reads are indeterminate.
// R22: In one-shot, pins serve as trigger input and pulse output.
// R23: Enabled pulse output stays active for the whole countdown.
`ifndef QOT_REGS_SVH
`define QOT_REGS_SVH
// ==========================================================
// Offsets
`define QOT_OFS_CTRL 8'h00
`define QOT_OFS_SHOT 8'h04
`define QOT_OFS_COUNT 8'h08
`define QOT_OFS_STATUS 8'h0C
// ==========================================================
// Control fields
`define QOT_CTRL_W 9
`define QOT_CTRL_START 0
`define QOT_CTRL_SHOT 1
`define QOT_CTRL_FREE 2
`define QOT_CTRL_X4 3
`define QOT_CTRL_SRC 4
`define QOT_CTRL_PULSE 6
`define QOT_CTRL_TRIG 7
`define QOT_CTRL_OVFTRIG 8
`define QOT_SHOT_GO 0
// ==========================================================
// Reset values and counts
`define QOT_CTRL_RST 9'h000
`define QOT_COUNT_RST 16'h0000
`define QOT_DIV8 8
`define QOT_DIV32 32
`endif

// ===== qot_pkg.sv
// Types shared by the timer channel modules
package qot_pkg;
    typedef enum logic [1:0]
    {
        QOT_CLOCK_UNDIVIDED = 2'h0,
        QOT_CLOCK_DIV8 = 2'h1,
        QOT_CLOCK_DIV32 = 2'h2,
        QOT_SUBCLOCK_DIV32 = 2'h3
    } qot_src_t;
    typedef enum logic [2:0]
    {
        QOT_IDLE = 3'h1,
        QOT_QUAD = 3'h2,
        QOT_SHOT = 3'h4
    } qot_state_t;
endpackage

// ===== qot_evt_if.sv
// Event signals between the channel core, its prescaler and its decoder
`timescale 1ns/100ps
interface qot_evt_if;
    import qot_pkg::*;
    qot_src_t src_sel;
    logic subclk;
    logic tick;
    logic pin_a;
    logic pin_b;
    logic x4;
    logic up;
    logic dn;
    modport presc (input src_sel, input subclk, output tick);
    modport dec (input pin_a, input pin_b, input x4, output up, output dn);
    modport core (output src_sel, output subclk, output pin_a, output pin_b, output x4,
        input tick, input up, input dn);
endinterface

// ===== qot_prescale.sv
// Count source prescaler for the one-shot countdown
`timescale 1ns/100ps
`include "qot_regs.svh"
module qot_prescale
    import qot_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    qot_evt_if.presc ev
);
    localparam logic [4:0] LAST8 = 5'(`QOT_DIV8 - 1);
    localparam logic [4:0] LAST32 = 5'(`QOT_DIV32 - 1);
    logic [4:0] d8_r, d8_nxt, d32_r, d32_nxt, sub_r, sub_nxt;
    logic sub_prev_r, tick_r, tick_nxt, sub_rise;
    // ==========================================================
    // Dividers
    always_comb
    begin
        sub_rise = ev.subclk & ~sub_prev_r;
        d8_nxt = (d8_r == LAST8) ? 5'h00 : d8_r + 5'h01;
        d32_nxt = (d32_r == LAST32) ? 5'h00 : d32_r + 5'h01;
        sub_nxt = sub_r;
        if (sub_rise)
            sub_nxt = (sub_r == LAST32) ? 5'h00 : sub_r + 5'h01;
        unique case (ev.src_sel) // [R15]
            QOT_CLOCK_UNDIVIDED: tick_nxt = 1'b1;
            QOT_CLOCK_DIV8: tick_nxt = (d8_r == LAST8);
            QOT_CLOCK_DIV32: tick_nxt = (d32_r == LAST32);
            QOT_SUBCLOCK_DIV32: tick_nxt = sub_rise && (sub_r == LAST32);
        endcase
    end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            d8_r <= 5'h00;
            d32_r <= 5'h00;
            sub_r <= 5'h00;
            sub_prev_r <= 1'b0;
            tick_r <= 1'b0;
        end
        else
        begin
            d8_r <= d8_nxt;
            d32_r <= d32_nxt;
            sub_r <= sub_nxt;
            sub_prev_r <= ev.subclk;
            tick_r <= tick_nxt;
        end
    end
    assign ev.tick = tick_r;
endmodule // qot_prescale

// ===== qot_quad_decode.sv
// Two-phase pulse decoder, normal and times-four
`timescale 1ns/100ps
module qot_quad_decode
(
    input wire logic i_clock,
    input wire logic i_rst,
    qot_evt_if.dec ev
);
    logic a_prev_r, b_prev_r, up_r, dn_r, up_nxt, dn_nxt;
    logic ar, af, br, bf;
    // ==========================================================
    // Edge decoding
    always_comb
    begin
        ar = ev.pin_a & ~a_prev_r;
        af = ~ev.pin_a & a_prev_r;
        br = ev.pin_b & ~b_prev_r & ~ar & ~af;
        bf = ~ev.pin_b & b_prev_r & ~ar & ~af;
        if (ev.x4)
        begin
            up_nxt = (ar & ev.pin_b) | (af & ~ev.pin_b) | (br & ~ev.pin_a) | (bf & ev.pin_a); // [R12]
            dn_nxt = (af & ev.pin_b) | (ar & ~ev.pin_b) | (br & ev.pin_a) | (bf & ~ev.pin_a); // [R13]
        end
        else
        begin
            up_nxt = ar & ev.pin_b; // [R11]
            dn_nxt = af & ev.pin_b; // [R11]
        end
    end
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            up_r <= 1'b0;
            dn_r <= 1'b0;
        end
        else
        begin
            a_prev_r <= ev.pin_a;
            b_prev_r <= ev.pin_b;
            up_r <= up_nxt;
            dn_r <= dn_nxt;
        end
    end
    assign ev.up = up_r;
    assign ev.dn = dn_r;
    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_normal_up_edge: assert property (!ev.x4 && $rose(ev.pin_a) && ev.pin_b |=> ev.up) // [R11]
        else $error("normal rise with high phase not counted up");
    a_x4_down_edge: assert property (ev.x4 && $fell(ev.pin_a) && ev.pin_b |=> ev.dn) // [R13]
        else $error("times four falling edge not counted down");
endmodule // qot_quad_decode

// ===== qot_top.sv
// Two-phase event counter and one-shot timer channel with an APB register slave
`timescale 1ns/100ps
`include "qot_regs.svh"
module qot_top
    import qot_pkg::*;
#(
    parameter int CHANNEL = 3
)
(
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_COUNT_IN_PIN,
    input wire logic I_COUNT_OUT_PIN,
    input wire logic I_SUBCLOCK,
    input wire logic I_SRC_OVF,
    output logic O_COUNT_OUT_PIN,
    output logic O_COUNT_OUT_OE,
    output logic O_IRQ
);
    // ==========================================================
    // Channel capabilities
    localparam logic QUAD_OK = (CHANNEL >= 2); // [R1]
    localparam logic X4_FIXED = (CHANNEL == 4);
    localparam logic X4_SEL = (CHANNEL == 3);

    qot_evt_if ev ();

    logic a_s1_r, a_s2_r, b_s1_r, b_s2_r, sub_s1_r, sub_s2_r, a_prev_r;
    logic [`QOT_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [15:0] cnt_r, cnt_nxt, reload_r, reload_nxt;
    qot_state_t state_r, state_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic irq_r, irq_nxt, out_r, out_nxt, oe_r, oe_nxt;
    logic start, shot_mode, free_run, pulse_en, trig_en, ovftrig_en, x4_eff;
    logic setup, acc, wr, hit, wr_ctrl, wr_cnt, sw_go, pin_trig, trig;
    logic ev_up, ev_dn;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            a_s1_r <= 1'b0;
            a_s2_r <= 1'b0;
            b_s1_r <= 1'b0;
            b_s2_r <= 1'b0;
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            a_prev_r <= 1'b0;
        end
        else
        begin
            a_s1_r <= I_COUNT_IN_PIN;
            a_s2_r <= a_s1_r;
            b_s1_r <= I_COUNT_OUT_PIN;
            b_s2_r <= b_s1_r;
            sub_s1_r <= I_SUBCLOCK;
            sub_s2_r <= sub_s1_r;
            a_prev_r <= a_s2_r;
        end
    end

    // ==========================================================
    // Control decode and submodules
    assign start = ctrl_r[`QOT_CTRL_START];
    assign shot_mode = ctrl_r[`QOT_CTRL_SHOT];
    assign free_run = ctrl_r[`QOT_CTRL_FREE];
    assign pulse_en = ctrl_r[`QOT_CTRL_PULSE];
    assign trig_en = ctrl_r[`QOT_CTRL_TRIG];
    assign ovftrig_en = ctrl_r[`QOT_CTRL_OVFTRIG];
    assign x4_eff = X4_FIXED | (X4_SEL & ctrl_r[`QOT_CTRL_X4]); // [R14]

    assign ev.src_sel = qot_src_t'(ctrl_r[`QOT_CTRL_SRC +: 2]);
    assign ev.subclk = sub_s2_r;
    assign ev.pin_a = a_s2_r; // [R2]
    assign ev.pin_b = b_s2_r; // [R2]
    assign ev.x4 = x4_eff;
    assign ev_up = ev.up & QUAD_OK;
    assign ev_dn = ev.dn & QUAD_OK;

    qot_prescale u_presc
    (
        .i_clock(I_CLOCK),
        .i_rst(I_RST),
        .ev(ev.presc)
    );

    qot_quad_decode u_dec
    (
        .i_clock(I_CLOCK),
        .i_rst(I_RST),
        .ev(ev.dec)
    );

    // ==========================================================
    // APB decode
    assign setup = I_PSEL & ~I_PENABLE;
    assign acc = I_PSEL & I_PENABLE & pready_r;
    assign wr = acc & I_PWRITE;
    assign wr_ctrl = wr && (I_PADDR == `QOT_OFS_CTRL);
    assign wr_cnt = wr && (I_PADDR == `QOT_OFS_COUNT);
    assign sw_go = wr && (I_PADDR == `QOT_OFS_SHOT) && I_PWDATA[`QOT_SHOT_GO];
    assign pin_trig = trig_en & a_s2_r & ~a_prev_r; // [R22]
    assign trig = sw_go | pin_trig | (ovftrig_en & I_SRC_OVF); // [R18]

    always_comb
    begin
        pready_nxt = setup;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        hit = 1'b1;
        unique case (I_PADDR)
            `QOT_OFS_CTRL: prdata_nxt = {23'h000000, ctrl_r};
            `QOT_OFS_SHOT: prdata_nxt = 32'h0000_0000;
            `QOT_OFS_COUNT: prdata_nxt = {16'h0000, cnt_r}; // [R9] [R21]
            `QOT_OFS_STATUS: prdata_nxt = {29'h0000_0000, QUAD_OK, x4_eff, state_r != QOT_IDLE};
            default: hit = 1'b0;
        endcase
        if (!setup || I_PWRITE)
            prdata_nxt = 32'h0000_0000;
        if (setup && !hit)
            pslverr_nxt = 1'b1;
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // ==========================================================
    // Counter and channel state
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        cnt_nxt = cnt_r;
        reload_nxt = reload_r;
        state_nxt = state_r;
        irq_nxt = 1'b0;
        if (wr_ctrl)
            ctrl_nxt = I_PWDATA[`QOT_CTRL_W-1:0];
        unique case (state_r)
            QOT_IDLE:
            begin
                if (start && !shot_mode && QUAD_OK)
                    state_nxt = QOT_QUAD; // [R6]
                else if (start && shot_mode && trig)
                begin
                    cnt_nxt = reload_r; // [R18]
                    state_nxt = QOT_SHOT;
                end
            end
            QOT_QUAD:
            begin
                if (!start || shot_mode)
                    state_nxt = QOT_IDLE; // [R6]
                else if (ev_up)
                begin
                    if (cnt_r == 16'hFFFF)
                    begin
                        irq_nxt = 1'b1; // [R7]
                        cnt_nxt = free_run ? 16'h0000 : reload_r; // [R3] [R4] [R5]
                    end
                    else
                        cnt_nxt = cnt_r + 16'h0001;
                end
                else if (ev_dn)
                begin
                    if (cnt_r == 16'h0000)
                    begin
                        irq_nxt = 1'b1; // [R7]
                        cnt_nxt = free_run ? 16'hFFFF : reload_r; // [R3] [R4] [R5]
                    end
                    else
                        cnt_nxt = cnt_r - 16'h0001;
                end
            end
            QOT_SHOT:
            begin
                if (!start || !shot_mode)
                    state_nxt = QOT_IDLE; // [R19]
                else if (trig)
                    cnt_nxt = reload_r; // [R17]
                else if (ev.tick)
                begin
                    if (cnt_r <= 16'h0001)
                    begin
                        irq_nxt = 1'b1; // [R20]
                        cnt_nxt = reload_r; // [R16]
                        state_nxt = QOT_IDLE; // [R16]
                    end
                    else
                        cnt_nxt = cnt_r - 16'h0001; // [R15]
                end
            end
        endcase
        if (wr_cnt)
        begin
            reload_nxt = I_PWDATA[15:0]; // [R10]
            if (state_r == QOT_IDLE)
                cnt_nxt = I_PWDATA[15:0]; // [R10]
        end
        oe_nxt = pulse_en & shot_mode; // [R22]
        out_nxt = pulse_en & shot_mode & (state_nxt == QOT_SHOT); // [R23]
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            ctrl_r <= `QOT_CTRL_RST;
            cnt_r <= `QOT_COUNT_RST;
            reload_r <= `QOT_COUNT_RST;
            state_r <= QOT_IDLE;
            irq_r <= 1'b0;
            out_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            reload_r <= reload_nxt;
            state_r <= state_nxt;
            irq_r <= irq_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign O_PRDATA = prdata_r;
    assign O_PREADY = pready_r;
    assign O_PSLVERR = pslverr_r;
    assign O_IRQ = irq_r;
    assign O_COUNT_OUT_PIN = out_r;
    assign O_COUNT_OUT_OE = oe_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    a_quad_reload_up: assert property (state_r == QOT_QUAD && start && !shot_mode // [R3]
        && !free_run && ev_up && cnt_r == 16'hFFFF && !wr_cnt |=> cnt_r == $past(reload_r))
        else $error("overflow did not reload");
    a_free_wrap: assert property (state_r == QOT_QUAD && start && !shot_mode && free_run // [R4]
        && ev_dn && !ev_up && cnt_r == 16'h0000 && !wr_cnt |=> cnt_r == 16'hFFFF)
        else $error("free run underflow did not wrap");
    a_quad_irq: assert property (state_r == QOT_QUAD && start && !shot_mode // [R7]
        && ev_up && cnt_r == 16'hFFFF |=> O_IRQ)
        else $error("overflow gave no interrupt");
    a_idle_hold: assert property (state_r == QOT_IDLE && !start && !wr_cnt // [R6]
        |=> $stable(cnt_r))
        else $error("stopped counter moved");
    a_write_stopped: assert property (wr_cnt && state_r == QOT_IDLE // [R10]
        |=> cnt_r == $past(I_PWDATA[15:0]) && reload_r == cnt_r)
        else $error("stopped write did not load both");
    a_write_running: assert property (wr_cnt && state_r == QOT_QUAD && start && !shot_mode // [R10]
        && !ev_up && !ev_dn |=> cnt_r == $past(cnt_r) && reload_r == $past(I_PWDATA[15:0]))
        else $error("running write disturbed the counter");
    a_shot_end: assert property (state_r == QOT_SHOT && start && shot_mode && !trig // [R16]
        && ev.tick && cnt_r == 16'h0001 && !wr_cnt
        |=> state_r == QOT_IDLE && O_IRQ && cnt_r == $past(reload_r))
        else $error("one-shot end wrong");
    a_shot_stop: assert property (state_r == QOT_SHOT && !start // [R19]
        |=> state_r == QOT_IDLE ##1 !O_COUNT_OUT_PIN)
        else $error("one-shot did not stop on clear");
    a_pulse_level: assert property (pulse_en && shot_mode && state_r == QOT_SHOT // [R23]
        && !$past(I_RST) && $past(pulse_en && shot_mode && state_r == QOT_SHOT)
        |-> O_COUNT_OUT_PIN)
        else $error("pulse output dropped during countdown");
    a_no_quad_low: assert property (!QUAD_OK |-> state_r != QOT_QUAD) // [R1]
        else $error("two-phase mode on a single-phase channel");

    a_quad_count_up: assert property (state_r == QOT_QUAD && start && !shot_mode // [R5]
        && ev_up && cnt_r != 16'hFFFF
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("up event not counted");

    a_quad_count_down: assert property (state_r == QOT_QUAD && start && !shot_mode // [R5]
        && ev_dn && !ev_up && cnt_r != 16'h0000
        |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("down event not counted");

    a_quad_stop: assert property (state_r == QOT_QUAD && !start // [R6]
        |=> state_r == QOT_IDLE)
        else $error("two-phase count did not stop");

    a_pin_start: assert property (state_r == QOT_IDLE && start && shot_mode // [R18]
        && pin_trig && !wr_cnt |=> state_r == QOT_SHOT && cnt_r == $past(reload_r))
        else $error("pin trigger did not start the one-shot");

    a_ovf_start: assert property (state_r == QOT_IDLE && start && shot_mode // [R18]
        && ovftrig_en && I_SRC_OVF |=> state_r == QOT_SHOT)
        else $error("source overflow did not start the one-shot");

    a_shot_retrig: assert property (state_r == QOT_SHOT && start && shot_mode // [R17]
        && trig |=> state_r == QOT_SHOT && cnt_r == $past(reload_r))
        else $error("trigger did not restart the countdown");

    a_shot_tick: assert property (state_r == QOT_SHOT && start && shot_mode // [R15]
        && !trig && ev.tick && cnt_r > 16'h0001
        |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("source tick not counted down");

    a_quad_no_oe: assert property (!shot_mode |=> !O_COUNT_OUT_OE) // [R22]
        else $error("pin driven outside one-shot mode");

    a_read_live: assert property (I_PSEL && !I_PENABLE && !I_PWRITE // [R9]
        && I_PADDR == `QOT_OFS_COUNT |=> O_PREADY && O_PRDATA == {16'h0000, $past(cnt_r)})
        else $error("count read not answered with the count");

    a_bad_addr: assert property (I_PSEL && !I_PENABLE && I_PADDR > `QOT_OFS_STATUS
        |=> O_PREADY && O_PSLVERR)
        else $error("unmapped address not refused");

    c_quad_overflow: cover property (state_r == QOT_QUAD && ev_up && cnt_r == 16'hFFFF);
    c_shot_done: cover property (state_r == QOT_SHOT ##1 state_r == QOT_IDLE && O_IRQ);
    c_shot_retrig: cover property (state_r == QOT_SHOT && trig && start && shot_mode);
    c_quad_underflow: cover property (state_r == QOT_QUAD && ev_dn && cnt_r == 16'h0000);
    c_pin_start: cover property (state_r == QOT_IDLE && start && shot_mode && pin_trig);
endmodule // qot_top

// ===== qot_pin_src.sv
// Two-phase encoder model driving the channel's pulse pins
`timescale 1ns/100ps
module qot_pin_src
(
    input wire logic i_clock,
    input wire logic i_step,
    input wire logic i_up,
    output logic o_pin_a,
    output logic o_pin_b
);
    // ==========================================================
    // Phase walk as {a,b}: 01, 11, 10, 00
    logic [1:0] phase_r = 2'h3;
    logic [1:0] phase_nxt;
    always_comb
    begin
        phase_nxt = phase_r;
        if (i_step)
            phase_nxt = i_up ? phase_r + 2'h1 : phase_r - 2'h1;
    end
    always @(posedge i_clock)
    begin
        phase_r <= phase_nxt;
    end
    // One pin moves per step; bench holds each level for several cycles
    assign o_pin_a = phase_r[0] ^ phase_r[1];
    // The bench replaces pin b with the channel's pulse output whenever the channel enables it
    assign o_pin_b = ~phase_r[1];
endmodule // qot_pin_src

// ===== qot_tb_top.sv
// Self-checking bench for the two-phase counter and one-shot channel
`timescale 1ns/100ps
`include "qot_regs.svh"
module qot_tb_top;
    // ==========================================================
    // Signals and bench model state
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, out_pin, out_oe, irq, pin_a, pin_b;
    logic subclk = 1'b0;
    logic src_ovf = 1'b0;
    logic step = 1'b0;
    logic up = 1'b0;
    logic x4 = 1'b0;
    logic free = 1'b0;
    logic run = 1'b0;
    logic err;
    logic [31:0] rd;
    integer seed = 32'h21D2;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer irq_cnt = 0;
    integer exp_irq = 0;
    integer cyc = 0;
    integer ph = 3;
    integer cnt, rld, t, n;
    integer dv [4] = '{1, 8, 32, 256};
    initial
    begin
        forever #4 clk = ~clk;
    end
    // Sub-clock at one eighth of the system rate, interrupt tally
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        subclk <= cyc[2];
        if (irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    end
    qot_pin_src enc_u (.i_clock(clk), .i_step(step), .i_up(up), .o_pin_a(pin_a), .o_pin_b(pin_b));
    qot_top #(.CHANNEL(3)) dut_u
    (
        .I_CLOCK(clk),
        .I_RST(rst),
        .I_PSEL(psel),
        .I_PENABLE(pen),
        .I_PWRITE(pwr),
        .I_PADDR(paddr),
        .I_PWDATA(pwdata),
        .O_PRDATA(prdata),
        .O_PREADY(pready),
        .O_PSLVERR(pslverr),
        .I_COUNT_IN_PIN(pin_a),
        .I_COUNT_OUT_PIN(out_oe === 1'b1 ? out_pin : pin_b),
        .I_SUBCLOCK(subclk),
        .I_SRC_OVF(src_ovf),
        .O_COUNT_OUT_PIN(out_pin),
        .O_COUNT_OUT_OE(out_oe),
        .O_IRQ(irq)
    );
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        chk("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic bump(input logic u);
        if ((u && cnt == 32'hFFFF) || (!u && cnt == 0))
        begin
            cnt = free ? (u ? 0 : 32'hFFFF) : rld;
            exp_irq++;
        end
        else
            cnt = u ? cnt + 1 : cnt - 1;
    endtask
    task automatic mv(input logic u);
        step <= 1'b1;
        up <= u;
        @(posedge clk);
        step <= 1'b0;
        if (run && (x4 || (u && ph == 0) || (!u && ph == 1)))
            bump(u);
        ph = u ? (ph + 1) % 4 : (ph + 3) % 4;
        repeat (3 + $unsigned($random(seed)) % 5) @(posedge clk);
    endtask
    task automatic arm(input logic [31:0] ctl, input integer cnt0);
        apb(1'b1, `QOT_OFS_COUNT, cnt0);
        apb(1'b1, `QOT_OFS_CTRL, ctl);
    endtask
    task automatic fire(input integer k);
        if (k == 0)
            apb(1'b1, `QOT_OFS_SHOT, 32'h1);
        else if (k == 1)
        begin
            while (ph == 1 || ph == 2)
                mv(1'b1);
            mv(ph == 0);
        end
        else
        begin
            src_ovf <= 1'b1;
            @(posedge clk);
            src_ovf <= 1'b0;
        end
    endtask
    task automatic meas(input logic pchk, output integer tw);
        integer gaps;
        tw = 0;
        gaps = 0;
        do
        begin
            @(posedge clk);
            tw++;
            if (irq !== 1'b1 && pchk && {out_pin, out_oe} !== 2'b11)
                gaps++;
        end
        while (irq !== 1'b1 && tw < 3000);
        chk("shot_irq", irq, 1'b1);
        chk("pulse_end", {30'h0, out_pin, out_oe}, 32'h1);
        chk("pulse_gaps", gaps, 32'h0);
        exp_irq++;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, `QOT_OFS_CTRL, 32'h0);
        chk("ctrl_rst", rd, `QOT_CTRL_RST);
        apb(1'b0, `QOT_OFS_COUNT, 32'h0);
        chk("count_rst", rd, `QOT_COUNT_RST);
        apb(1'b1, 8'h10, 32'hFFFF);
        chk("bad_wr", err, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk("bad_rd", {rd[30:0], err}, 32'h1);
        for (int c = 0; c < 4; c++)
        begin
            x4 = c[0];
            free = c[1];
            rld = (c[0] ^ c[1]) ? 32'hFFFE : 32'h1;
            cnt = rld;
            arm({28'h0, x4, free, 2'h1}, rld);
            run = 1'b1;
            apb(1'b0, `QOT_OFS_STATUS, 32'h0);
            chk("status", rd[2:0], {1'b1, x4, 1'b1});
            chk("oe_quad", out_oe, 1'b0);
            for (int s = 0; s < 60; s++)
            begin
                mv((c[0] ^ c[1]) ^ (($unsigned($random(seed)) % 4) == 0));
                if (s == 30)
                begin
                    rld = (c[0] ^ c[1]) ? 32'hFFFD : 32'h2;
                    apb(1'b1, `QOT_OFS_COUNT, rld);
                end
                if (s % 10 == 9)
                begin
                    apb(1'b0, `QOT_OFS_COUNT, 32'h0);
                    chk("count", rd, cnt);
                end
            end
            apb(1'b1, `QOT_OFS_CTRL, {28'h0, x4, free, 2'h0});
            run = 1'b0;
            mv(1'b1);
            mv(1'b0);
            mv(1'b0);
            apb(1'b0, `QOT_OFS_COUNT, 32'h0);
            chk("count_held", rd, cnt);
        end
        repeat (8) @(posedge clk);
        chk("irq_quad", irq_cnt, exp_irq);
        for (int s = 0; s < 4; s++)
        begin
            n = 2 + $unsigned($random(seed)) % 4;
            arm(32'h1C3 | (s << 4), n);
            fire(0);
            meas(1'b1, t);
            chk("shot_time", t >= (n - 1) * dv[s] && t <= (n + 1) * dv[s] + 8, 1'b1);
            apb(1'b0, `QOT_OFS_STATUS, 32'h0);
            chk("shot_done", rd[0], 1'b0);
        end
        for (int k = 0; k < 3; k++)
        begin
            arm(32'h1C3, 20);
            fire(k);
            meas(k != 1, t);
            chk("trig_time", t > 8 && t < 30, 1'b1);
        end
        arm(32'h43, 30);
        fire(0);
        repeat (15) @(posedge clk);
        fire(0);
        meas(1'b1, t);
        chk("retrigger", t > 25 && t < 35, 1'b1);
        arm(32'h43, 40);
        fire(0);
        repeat (10) @(posedge clk);
        apb(1'b1, `QOT_OFS_CTRL, 32'h42);
        repeat (60) @(posedge clk);
        apb(1'b0, `QOT_OFS_STATUS, 32'h0);
        chk("halted", rd[0], 1'b0);
        chk("out_halt", out_pin, 1'b0);
        chk("irq_total", irq_cnt, exp_irq);
        give_verdict;
    end
    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        give_verdict;
    end
endmodule // qot_tb_top
